// ### usdp_cfg.svh
// address map, field positions, reset values and timing counts of the shadow data port
`ifndef USDP_CFG_SVH
`define USDP_CFG_SVH
`define USDP_SHADOW_BASE 32'h5000_1130
`define USDP_SHADOW_ALIAS3 32'h5000_113c
`define USDP_SHADOW_ALIAS15 32'h5000_116c
`define USDP_SHADOW_SPAN 32'h0000_0040
`define USDP_CTRL_ADDR 32'h5000_1180
`define USDP_LINE_ADDR 32'h5000_1184
`define USDP_IRQ_STAT_ADDR 32'h5000_1188
`define USDP_IRQ_MASK_ADDR 32'h5000_118c
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_LINE_DR 0
`define USDP_LINE_OE 1
`define USDP_LINE_TX_HOLDING_EMPTY_FLAG 5
`define USDP_LINE_TEMT 6
`define USDP_EV_RX 0
`define USDP_EV_OVR 1
`define USDP_EV_TX_HOLDING_EMPTY_FLAG 2
`define USDP_EV_DROP 3
`define USDP_REG_RESET 16'h0000
`define USDP_FIFO_WORDS 16
`define USDP_FIFO_FULL 5'd16
`define USDP_BIT_CYC 16'd16
`define USDP_BIT_HALF (`USDP_BIT_CYC >> 1)
`define USDP_BIT_LAST (`USDP_BIT_CYC - 16'd1)
`define USDP_IR_PULSE_CYC (`USDP_BIT_CYC * 16'd3 / 16'd16)
`endif

// ### usdp_pkg.sv
// types of the shadow data port
package usdp_pkg;
	typedef enum logic [1:0] {
		USDP_IDLE = 2'b00,
		USDP_START = 2'b01,
		USDP_DATA = 2'b11,
		USDP_STOP = 2'b10
	} usdp_ser_state_type;

	typedef struct packed {
		logic [31:0] rdata;
		logic fifo_en;
		logic ir_mode;
		logic overrun;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic irq;
		logic tx_holding_empty_flag_prev;
		usdp_ser_state_type rx_st;
		logic [15:0] rx_cnt;
		logic [2:0] rx_bit;
		logic rx_bitval;
		logic [7:0] rx_shift;
		usdp_ser_state_type tx_st;
		logic [15:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_shift;
		logic ser_out;
		logic ir_out_n;
	} usdp_state_type;
endpackage : usdp_pkg

// ### usdp_fifo.sv
// character fifo with simultaneous push and pop, used for both directions
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module usdp_fifo (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] head_data,
	output logic [4:0] count
);
	typedef struct packed {
		logic [`USDP_FIFO_WORDS-1:0][7:0] mem;
		logic [3:0] wr_ptr;
		logic [3:0] rd_ptr;
		logic [4:0] cnt;
	} usdp_fifo_state_type;

	usdp_fifo_state_type q;
	usdp_fifo_state_type d;
	logic do_pop;
	logic do_push;

	always_comb
	begin
		d = q;
		do_pop = pop && (q.cnt != 5'd0);
		// a full fifo still takes a push when a pop frees the slot in the same cycle
		do_push = push && ((q.cnt != `USDP_FIFO_FULL) || do_pop);
		if (flush)
		begin
			d.wr_ptr = 4'h0;
			d.rd_ptr = 4'h0;
			d.cnt = 5'h00;
		end
		else
		begin
			if (do_push)
			begin
				d.mem[q.wr_ptr] = push_data;
				d.wr_ptr = q.wr_ptr + 4'h1;
			end
			if (do_pop)
				d.rd_ptr = q.rd_ptr + 4'h1;
			d.cnt = q.cnt + {4'h0, do_push} - {4'h0, do_pop};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign head_data = q.mem[q.rd_ptr];
	assign count = q.cnt;
endmodule : usdp_fifo

// ### usdp_top.sv
// shadow receive/transmit data port with serial and infrared links
//Contract
// - sixteen word aliases reach the data port
// - read low byte gives received character
// - received data valid only with ready flag
// - fifo off: new character overwrites, overrun
// - fifo on: read pops oldest entry
// - full receive fifo drops new, overrun
// - write low byte sends character out
// - fifo off: write clears empty, overwrites
// - fifo on: sixteen characters before full
// - write into full transmit fifo dropped
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module usdp_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic ser_in,
	input wire logic ir_in,
	output logic ser_out,
	output logic ir_out_n,
	output logic irq
);
	import usdp_pkg::*;

	usdp_pkg::usdp_state_type q;
	usdp_pkg::usdp_state_type d;
	logic [7:0] rx_head;
	logic [4:0] rx_count;
	logic [7:0] tx_head;
	logic [4:0] tx_count;
	logic rx_push;
	logic rx_pop;
	logic rx_pop_rd;
	logic rx_done;
	logic rx_overwrite;
	logic rx_drop;
	logic tx_push;
	logic tx_pop;
	logic tx_load;
	logic tx_full;
	logic tx_drop;
	logic tx_overwrite;
	logic tx_holding_empty_flag;
	logic flush;
	logic wr_shadow;
	logic rd_shadow;
	logic tx_line;
	logic [3:0] ev;
	logic [31:0] rd_mux;

	function automatic logic is_shadow(input logic [31:0] a);
		is_shadow = (a >= `USDP_SHADOW_BASE) && (a < (`USDP_SHADOW_BASE + `USDP_SHADOW_SPAN)) && (a[1:0] == 2'b00);
	endfunction : is_shadow

	assign wr_shadow = bus_wr && is_shadow(bus_addr);
	assign rd_shadow = bus_rd && is_shadow(bus_addr);
	assign tx_holding_empty_flag = (tx_count == 5'd0);

	usdp_fifo rx_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flush(flush),
		.push(rx_push),
		.push_data(q.rx_shift),
		.pop(rx_pop),
		.head_data(rx_head),
		.count(rx_count)
	);

	usdp_fifo tx_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flush(flush),
		.push(tx_push),
		.push_data(bus_wdata[7:0]),
		.pop(tx_pop),
		.head_data(tx_head),
		.count(tx_count)
	);

	always_comb
	begin
		d = q;
		rx_done = 1'b0;
		flush = 1'b0;
		rd_mux = 32'h0000_0000;

		// receive deserializer; ir mode sees a pulse anywhere in a bit but its last cycle as a zero
		unique case (q.rx_st)
			USDP_IDLE:
			begin
				if (q.ir_mode ? ir_in : !ser_in)
				begin
					d.rx_st = USDP_START;
					d.rx_cnt = 16'h0000;
					d.rx_bitval = 1'b0;
				end
			end
			USDP_START, USDP_DATA, USDP_STOP:
			begin
				d.rx_cnt = q.rx_cnt + 16'h0001;
				if (q.ir_mode && ir_in)
					d.rx_bitval = 1'b0;
				if (!q.ir_mode && (q.rx_cnt == `USDP_BIT_HALF))
					d.rx_bitval = ser_in;
				if (q.rx_cnt == `USDP_BIT_LAST)
				begin
					d.rx_cnt = 16'h0000;
					d.rx_bitval = 1'b1;
					if (q.rx_st == USDP_START)
					begin
						// a start bit that read back high was a glitch
						d.rx_st = q.rx_bitval ? USDP_IDLE : USDP_DATA;
						d.rx_bit = 3'h0;
					end
					else if (q.rx_st == USDP_DATA)
					begin
						d.rx_shift = {q.rx_bitval, q.rx_shift[7:1]};
						d.rx_bit = q.rx_bit + 3'h1;
						if (q.rx_bit == 3'h7)
							d.rx_st = USDP_STOP;
					end
					else
					begin
						d.rx_st = USDP_IDLE;
						rx_done = 1'b1;
					end
				end
			end
		endcase

		rx_pop_rd = rd_shadow && (rx_count != 5'd0);
		rx_overwrite = rx_done && !q.fifo_en && (rx_count != 5'd0) && !rx_pop_rd;
		rx_drop = rx_done && q.fifo_en && (rx_count == `USDP_FIFO_FULL) && !rx_pop_rd;
		rx_pop = rx_pop_rd || rx_overwrite;
		rx_push = rx_done && !rx_drop;

		// transmit side: holding slot of one when fifos are off
		tx_load = (q.tx_st == USDP_IDLE) && (tx_count != 5'd0);
		tx_full = q.fifo_en ? (tx_count == `USDP_FIFO_FULL) : (tx_count != 5'd0);
		tx_drop = wr_shadow && q.fifo_en && tx_full && !tx_load;
		tx_overwrite = wr_shadow && !q.fifo_en && tx_full && !tx_load;
		tx_push = wr_shadow && !tx_drop;
		tx_pop = tx_load || tx_overwrite;

		unique case (q.tx_st)
			USDP_IDLE:
			begin
				if (tx_load)
				begin
					d.tx_st = USDP_START;
					d.tx_shift = tx_head;
					d.tx_cnt = 16'h0000;
				end
			end
			USDP_START, USDP_DATA, USDP_STOP:
			begin
				d.tx_cnt = q.tx_cnt + 16'h0001;
				if (q.tx_cnt == `USDP_BIT_LAST)
				begin
					d.tx_cnt = 16'h0000;
					if (q.tx_st == USDP_START)
					begin
						d.tx_st = USDP_DATA;
						d.tx_bit = 3'h0;
					end
					else if (q.tx_st == USDP_DATA)
					begin
						d.tx_shift = {1'b0, q.tx_shift[7:1]};
						d.tx_bit = q.tx_bit + 3'h1;
						if (q.tx_bit == 3'h7)
							d.tx_st = USDP_STOP;
					end
					else
						d.tx_st = USDP_IDLE;
				end
			end
		endcase

		tx_line = (d.tx_st == USDP_START) ? 1'b0 : ((d.tx_st == USDP_DATA) ? d.tx_shift[0] : 1'b1);
		d.ser_out = q.ir_mode ? 1'b1 : tx_line;
		// a zero bit is a short low pulse of three sixteenths of the bit time
		d.ir_out_n = !(q.ir_mode && !tx_line && (d.tx_cnt < `USDP_IR_PULSE_CYC));

		// register reads; data stands only in the cycle after the strobe
		if (rd_shadow)
			// low byte is the head character
			rd_mux = {24'h00_0000, (rx_count != 5'd0) ? rx_head : 8'h00};
		else if (bus_addr == `USDP_CTRL_ADDR)
		begin
			rd_mux[`USDP_CTRL_FIFO_EN] = q.fifo_en;
			rd_mux[`USDP_CTRL_IR_MODE] = q.ir_mode;
		end
		else if (bus_addr == `USDP_LINE_ADDR)
		begin
			rd_mux[`USDP_LINE_DR] = (rx_count != 5'd0);
			rd_mux[`USDP_LINE_OE] = q.overrun;
			rd_mux[`USDP_LINE_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
			rd_mux[`USDP_LINE_TEMT] = tx_holding_empty_flag && (q.tx_st == USDP_IDLE);
		end
		else if (bus_addr == `USDP_IRQ_STAT_ADDR)
			rd_mux = {28'h000_0000, q.irq_stat};
		else if (bus_addr == `USDP_IRQ_MASK_ADDR)
			rd_mux = {28'h000_0000, q.irq_mask};
		d.rdata = bus_rd ? rd_mux : 32'h0000_0000;

		// overrun flag clears on a line state read; a new overrun wins
		if (bus_rd && (bus_addr == `USDP_LINE_ADDR))
			d.overrun = 1'b0;
		if (rx_overwrite || rx_drop)
			d.overrun = 1'b1;

		if (bus_wr && (bus_addr == `USDP_CTRL_ADDR))
		begin
			d.fifo_en = bus_wdata[`USDP_CTRL_FIFO_EN];
			d.ir_mode = bus_wdata[`USDP_CTRL_IR_MODE];
			// changing the fifo mode empties both queues, since capacities differ
			flush = (bus_wdata[`USDP_CTRL_FIFO_EN] != q.fifo_en);
		end
		if (bus_wr && (bus_addr == `USDP_IRQ_MASK_ADDR))
			d.irq_mask = bus_wdata[3:0];

		ev = 4'h0;
		ev[`USDP_EV_RX] = rx_push;
		ev[`USDP_EV_OVR] = rx_overwrite || rx_drop;
		ev[`USDP_EV_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag && !q.tx_holding_empty_flag_prev;
		ev[`USDP_EV_DROP] = tx_drop;
		d.tx_holding_empty_flag_prev = tx_holding_empty_flag;
		// write one to clear; an event in the same cycle keeps its bit set
		if (bus_wr && (bus_addr == `USDP_IRQ_STAT_ADDR))
			d.irq_stat = q.irq_stat & ~bus_wdata[3:0];
		d.irq_stat = d.irq_stat | ev;
		d.irq = |(d.irq_stat & d.irq_mask);
	end

	// everything resets to zero, idle lines and the previous holding empty flag high
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.ser_out <= 1'b1;
			q.ir_out_n <= 1'b1;
			q.tx_holding_empty_flag_prev <= 1'b1;
		end
		else
			q <= d;
	end

	assign bus_rdata = q.rdata;
	assign ser_out = q.ser_out;
	assign ir_out_n = q.ir_out_n;
	assign irq = q.irq;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_ALIAS_LAST: assert property (bus_rd && (bus_addr == `USDP_SHADOW_ALIAS15) && (rx_count != 5'd0)
		|=> bus_rdata[7:0] == $past(rx_head))
		else $error("last alias did not return head");

	AST_RD_DATA: assert property (rd_shadow && (rx_count != 5'd0)
		|=> bus_rdata == {24'h00_0000, $past(rx_head)})
		else $error("shadow read data wrong");

	AST_RX_PUSH: assert property (rx_push && !rx_pop && !flush
		|=> rx_count == $past(rx_count) + 5'd1)
		else $error("received character not stored");

	AST_RD_INVALID: assert property (rd_shadow && (rx_count == 5'd0) && !rx_done
		|=> (bus_rdata == 32'h0000_0000) && (rx_count == $past(rx_count)))
		else $error("empty read not zero");

	AST_RX_OVERWRITE: assert property (rx_overwrite
		|=> q.overrun && (rx_count == 5'd1) && (rx_head == $past(q.rx_shift)))
		else $error("overwrite failed");

	AST_RX_POP: assert property (rd_shadow && q.fifo_en && (rx_count > 5'd1) && !rx_done
		|=> rx_count == $past(rx_count) - 5'd1)
		else $error("read did not pop");

	AST_RX_DROP: assert property (rx_drop
		|=> (rx_count == `USDP_FIFO_FULL) && (rx_head == $past(rx_head)) && q.overrun)
		else $error("drop wrong");

	AST_TX_START: assert property ((q.tx_st == USDP_IDLE) && (tx_count != 5'd0)
		|=> (q.tx_st == USDP_START) && (q.ir_mode ? !ir_out_n : !ser_out))
		else $error("no start bit");

	AST_IR_PULSE: assert property (q.ir_mode && (q.tx_st == USDP_START) && (q.tx_cnt == 16'h0000)
		|-> !ir_out_n ##3 ir_out_n)
		else $error("infrared start pulse wrong");

	AST_SER_IR_IDLE: assert property ($past(q.ir_mode)
		|-> ser_out)
		else $error("serial output moved in infrared mode");

	AST_TX_HOLDING_EMPTY_FLAG_CLEAR: assert property (wr_shadow && !q.fifo_en && tx_holding_empty_flag
		|=> !tx_holding_empty_flag && (tx_count == 5'd1))
		else $error("write did not clear holding empty");

	AST_THR_OVERWRITE: assert property (tx_overwrite
		|=> (tx_count == 5'd1) && (tx_head == $past(bus_wdata[7:0])) && !tx_holding_empty_flag)
		else $error("hold overwrite");

	AST_TX_DEPTH: assert property (wr_shadow && q.fifo_en && (tx_count < `USDP_FIFO_FULL) && !tx_load
		|=> tx_count == $past(tx_count) + 5'd1)
		else $error("fifo did not accept");

	AST_TX_FULL_DROP: assert property (tx_drop
		|=> (tx_count == `USDP_FIFO_FULL) && q.irq_stat[`USDP_EV_DROP])
		else $error("full write queued");

	AST_TX_DROP_KEEPS: assert property (tx_drop
		|=> tx_head == $past(tx_head))
		else $error("dropped write disturbed the queue head");

	AST_RESERVED: assert property ($past(rd_shadow)
		|-> bus_rdata[31:8] == 24'h00_0000)
		else $error("reserved bits not zero");

	COV_RX_DROP: cover property (rx_drop);
	COV_TX_DROP: cover property (tx_drop);
	COV_HOLD_OVERWRITE: cover property (tx_overwrite);
	COV_IRQ: cover property (!irq ##1 irq);
	COV_IR_RX: cover property (q.ir_mode && rx_done);
endmodule : usdp_top

// ### usdp_peer.sv
// serial peer model: sends frames to the receiver, collects frames from the transmitter
`timescale 1ns/1ps
module usdp_peer (
	input wire logic sys_clk,
	input wire logic ser_out,
	input wire logic ir_out_n,
	output logic ser_in,
	output logic ir_in
);
	logic [7:0] got[$];
	logic [7:0] sh;
	logic [7:0] shi;
	initial ser_in = 1'b1;
	initial ir_in = 1'b0;
	// 8N1 lsb first
	// longer stop keeps the far receiver from drifting
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			ser_in <= f[i];
			repeat ((i == 9) ? 20 : 16) @(posedge sys_clk);
		end
	endtask : send
	// infrared: a zero bit is a three cycle pulse at its start
	task automatic send_ir(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			ir_in <= !f[i];
			repeat (3) @(posedge sys_clk);
			ir_in <= 1'b0;
			repeat ((i == 9) ? 17 : 13) @(posedge sys_clk);
		end
	endtask : send_ir
	always
	begin
		@(negedge ser_out);
		repeat (24) @(posedge sys_clk);
		for (int i = 0; i < 8; i++)
		begin
			sh[i] = ser_out;
			repeat (16) @(posedge sys_clk);
		end
		got.push_back(sh);
	end
	// infrared: low early in a bit is a zero
	always
	begin
		@(negedge ir_out_n);
		repeat (17) @(posedge sys_clk);
		for (int i = 0; i < 8; i++)
		begin
			shi[i] = ir_out_n;
			repeat (16) @(posedge sys_clk);
		end
		got.push_back(shi);
	end
endmodule : usdp_peer

// ### uart_shadow_data_port_tb.sv
// self-checking bench of the shadow data port
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module uart_shadow_data_port_tb;
	import usdp_pkg::*;
	logic sys_clk, rst_n, bus_wr, bus_rd, ser_in, ir_in, ser_out, ir_out_n, irq;
	logic [31:0] bus_addr, bus_wdata, bus_rdata, d;
	int miscompares, tests_run, cyc;
	usdp_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .ser_in(ser_in), .ir_in(ir_in),
		.ser_out(ser_out), .ir_out_n(ir_out_n), .irq(irq));
	usdp_peer peer (.sys_clk(sys_clk), .ser_out(ser_out), .ir_out_n(ir_out_n),
		.ser_in(ser_in), .ir_in(ir_in));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		$display("errors %0d of %0d checks", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// sized so a hang ends well after the longest legal run
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		#1;
	endtask : wr
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 v = bus_rdata;
	endtask : rd
	task automatic wait_tx_holding_empty_flag;
		d = 0;
		while (d[5] !== 1'b1)
			rd(`USDP_LINE_ADDR, d);
	endtask : wait_tx_holding_empty_flag
	task automatic t_reset;
		rd(`USDP_CTRL_ADDR, d);
		chk("ctrl", 32'h0, d);
		rd(`USDP_LINE_ADDR, d);
		chk("line", 32'h60, d);
		rd(`USDP_SHADOW_ALIAS3, d);
		chk("empty rx", 32'h0, d);
		rd(32'h5000_1170, d);
		chk("unmapped", 32'h0, d);
		rd(`USDP_IRQ_STAT_ADDR, d);
		chk("stat", 32'h0, d);
	endtask : t_reset
	task automatic t_rx_off;
		peer.send(8'h11);
		peer.send(8'ha5);
		repeat (4) @(posedge sys_clk);
		rd(`USDP_LINE_ADDR, d);
		chk("line ovr", 32'h63, d);
		rd(`USDP_SHADOW_ALIAS3, d);
		chk("rx data", 32'ha5, d);
		rd(`USDP_LINE_ADDR, d);
		chk("line idle", 32'h60, d);
	endtask : t_rx_off
	task automatic t_tx_off;
		wait_tx_holding_empty_flag();
		wr(`USDP_SHADOW_ALIAS3, 32'h41);
		repeat (4) @(posedge sys_clk);
		wr(`USDP_SHADOW_ALIAS3, 32'h5a);
		wr(`USDP_SHADOW_ALIAS3, 32'hffff_ffc3);
		rd(`USDP_LINE_ADDR, d);
		chk("tx_holding_empty_flag clr", 32'h0, d);
		repeat (400) @(posedge sys_clk);
		chk("tx n", 32'h2, 32'(peer.got.size()));
		chk("tx0", 32'h41, {24'h0, peer.got[0]});
		chk("tx1", 32'hc3, {24'h0, peer.got[1]});
	endtask : t_tx_off
	task automatic t_rx_on;
		wr(`USDP_CTRL_ADDR, 32'h1);
		for (int i = 0; i < 17; i++)
			peer.send(8'h30 + 8'(i));
		repeat (4) @(posedge sys_clk);
		rd(`USDP_LINE_ADDR, d);
		chk("full ovr", 32'h63, d);
		for (int i = 0; i < 16; i++)
		begin
			rd(`USDP_SHADOW_BASE + 32'(4 * i), d);
			chk("fifo", 32'h30 + 32'(i), d);
		end
		rd(`USDP_SHADOW_ALIAS3, d);
		chk("lost", 32'h0, d);
	endtask : t_rx_on
	task automatic t_tx_on;
		peer.got.delete();
		wait_tx_holding_empty_flag();
		wr(`USDP_SHADOW_ALIAS15, 32'h80);
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 17; i++)
			wr(`USDP_SHADOW_BASE + 32'(4 * (i % 16)), 32'h81 + 32'(i));
		repeat (2900) @(posedge sys_clk);
		chk("tx n", 32'd17, 32'(peer.got.size()));
		for (int i = 0; i < 17; i++)
			chk("txq", 32'h80 + 32'(i), {24'h0, peer.got[i]});
		rd(`USDP_IRQ_STAT_ADDR, d);
		chk("drop", 32'h8, d & 32'h8);
	endtask : t_tx_on
	task automatic t_ir;
		peer.got.delete();
		wr(`USDP_IRQ_STAT_ADDR, 32'h7);
		wr(`USDP_CTRL_ADDR, 32'h2);
		peer.send_ir(8'h5c);
		repeat (4) @(posedge sys_clk);
		rd(`USDP_SHADOW_ALIAS3, d);
		chk("ir rx", 32'h5c, d);
		wait_tx_holding_empty_flag();
		wr(`USDP_SHADOW_ALIAS3, 32'h3a);
		repeat (200) @(posedge sys_clk);
		chk("ir n", 32'h1, 32'(peer.got.size()));
		chk("ir tx", 32'h3a, {24'h0, peer.got[0]});
		rd(`USDP_IRQ_STAT_ADDR, d);
		chk("ir stat", 32'hd, d);
		wr(`USDP_CTRL_ADDR, 32'h0);
	endtask : t_ir
	task automatic t_irq;
		wr(`USDP_IRQ_MASK_ADDR, 32'h8);
		@(posedge sys_clk);
		#1 chk("irq on", 32'h1, {31'h0, irq});
		wr(`USDP_IRQ_MASK_ADDR, 32'h0);
		@(posedge sys_clk);
		#1 chk("irq mask", 32'h0, {31'h0, irq});
		wr(`USDP_IRQ_MASK_ADDR, 32'h8);
		wr(`USDP_IRQ_STAT_ADDR, 32'h8);
		@(posedge sys_clk);
		#1 chk("irq clr", 32'h0, {31'h0, irq});
		chk("ir idle", 32'h1, {31'h0, ir_out_n});
	endtask : t_irq
	initial
	begin
		rst_n = 1'b0;
		bus_addr = 32'h0;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_rx_off();
		t_tx_off();
		t_rx_on();
		t_tx_on();
		t_ir();
		t_irq();
		close_out();
	end
endmodule : uart_shadow_data_port_tb
